// ### hw/rf_link_cfg_pkg.sv
`default_nettype none

package rf_link_cfg_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] ADDR_RESERVED_SLOT_A = 6'h0f;
  localparam logic [5:0] ADDR_RESERVED_SLOT_B = 6'h10;
  localparam logic [5:0] ADDR_GENERAL_LINK_CONFIG = 6'h11;
  localparam logic [5:0] ADDR_TRANSMIT_LINK_CONFIG = 6'h12;

  localparam logic [7:0] RST_RESERVED_SLOT = 8'h00;
  localparam logic [7:0] RST_GENERAL_LINK_CONFIG = 8'h3f;
  localparam logic [7:0] RST_TRANSMIT_LINK_CONFIG = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ------------------------------------------------------------
  // Field layout of general_link_config
  // ------------------------------------------------------------
  localparam int GEN_CRC_ORDER_SELECT_BIT = 7;
  localparam int GEN_TX_FIELD_GATING_BIT = 5;
  localparam int GEN_AUX_INPUT_POLARITY_BIT = 3;
  localparam int GEN_CRC_SEED_SELECT_LSB = 0;
  localparam logic [7:0] GEN_WRITE_MASK = 8'ha3 | 8'h08;

  // ------------------------------------------------------------
  // Field layout of transmit_link_config
  // ------------------------------------------------------------
  localparam int TX_CRC_APPEND_EN_BIT = 7;
  localparam int TX_RATE_SELECT_LSB = 4;
  localparam int TX_MODULATION_INVERT_BIT = 3;
  localparam logic [7:0] TX_WRITE_MASK = 8'hf8;

  // ------------------------------------------------------------
  // Codes and values
  // ------------------------------------------------------------
  localparam logic [2:0] RATE_106 = 3'h0;
  localparam logic [2:0] RATE_212 = 3'h1;
  localparam logic [2:0] RATE_424 = 3'h2;
  localparam logic [2:0] RATE_848 = 3'h3;

  localparam logic [15:0] CRC_SEED_00 = 16'h0000;
  localparam logic [15:0] CRC_SEED_01 = 16'h6363;
  localparam logic [15:0] CRC_SEED_10 = 16'ha671;
  localparam logic [15:0] CRC_SEED_11 = 16'hffff;
  // Type A framing at every supported rate starts from the same seed
  localparam logic [15:0] CRC_AUTO_SEED = CRC_SEED_01;

  // Writable bits take the new value, others keep what they hold
  function automatic logic [7:0] merge_write(input logic [7:0] old_val,
                                             input logic [7:0] new_val,
                                             input logic [7:0] mask);
    merge_write = (old_val & ~mask) | (new_val & mask);
  endfunction

endpackage

`default_nettype wire

// ### hw/crc_cfg_if.sv
`timescale 1ns/1ns
`default_nettype none

interface crc_cfg_if;
  logic order_select;
  logic [1:0] seed_select;
  logic rf_active;
  logic [15:0] raw_result;
  logic [15:0] seed;
  logic [15:0] result;
  logic msb_first;

  modport cfg (
    output order_select,
    output seed_select,
    output rf_active,
    output raw_result,
    input seed,
    input result,
    input msb_first
  );

  modport unit (
    input order_select,
    input seed_select,
    input rf_active,
    input raw_result,
    output seed,
    output result,
    output msb_first
  );
endinterface

`default_nettype wire

// ### hw/crc_seed_unit.sv
`timescale 1ns/1ns
`default_nettype none

module crc_seed_unit (
  crc_cfg_if.unit crc
);

  function automatic logic [7:0] reverse8(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
    begin
      reverse8[i] = v[7 - i];
    end
  endfunction

  always_comb
  begin
    // Order select only steers the stand-alone calculation
    crc.msb_first = crc.order_select & ~crc.rf_active;
    if (crc.msb_first)
    begin
      crc.result = {reverse8(crc.raw_result[15:8]), reverse8(crc.raw_result[7:0])};
    end
    else
    begin
      crc.result = crc.raw_result;
    end
    if (crc.rf_active)
    begin
      crc.seed = rf_link_cfg_pkg::CRC_AUTO_SEED;
    end
    else
    begin
      case (crc.seed_select)
        2'h0: crc.seed = rf_link_cfg_pkg::CRC_SEED_00;
        2'h1: crc.seed = rf_link_cfg_pkg::CRC_SEED_01;
        2'h2: crc.seed = rf_link_cfg_pkg::CRC_SEED_10;
        default: crc.seed = rf_link_cfg_pkg::CRC_SEED_11;
      endcase
    end
  end

endmodule

`default_nettype wire

// ### hw/rf_link_mode_config_regs.sv
`timescale 1ns/1ns
`default_nettype none

// Operation
// - With CRC order select set, the CRC runs MSB first and both result bytes read bit-reversed.
// - CRC order select is ignored during RF communication and only affects stand-alone CRC.
// - With field gating set, a transmitter start is refused unless the RF field is on.
// - The aux envelope input is active high when its polarity bit is one, else active low.
// - Any change written to the aux polarity bit raises the aux input activity event.
// - For stand-alone CRC the seed select picks 0000h, 6363h, A671h or FFFFh.
// - During RF communication the seed select is ignored and the seed comes automatically.
// - With transmit CRC enable set, a CRC is appended to each transmitted frame.
// - The rate field selects 106, 212, 424 or 848 kBd; codes 100 to 111 are reserved.
// - With modulation invert set, modulation of transmitted data is inverted.
// - The general mode register at 11h resets to 3Fh.
// - The transmit mode register at 12h resets to 00h.
// - Addresses 0Fh and 10h are reserved with no function and reset value 00h.
module rf_link_mode_config_regs (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic rf_comm_active_in,
  input wire logic [15:0] crc_raw_in,
  input wire logic tx_start_req_in,
  input wire logic rf_field_on_in,
  input wire logic tx_frame_end_in,
  input wire logic tx_data_in,
  input wire logic aux_envelope_input_in,
  output logic [7:0] reg_rdata_out,
  output logic [15:0] crc_seed_out,
  output logic [15:0] crc_result_value_out,
  output logic crc_msb_first_out,
  output logic tx_start_out,
  output logic tx_start_refused_out,
  output logic tx_crc_append_out,
  output logic tx_crc_append_en_out,
  output logic [2:0] tx_rate_select_out,
  output logic tx_rate_reserved_out,
  output logic tx_mod_data_out,
  output logic aux_envelope_n_out,
  output logic aux_input_activity_irq_out
);

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [7:0] general_link_config_ff;
  logic [7:0] nxt_general_link_config;
  logic [7:0] transmit_link_config_ff;
  logic [7:0] nxt_transmit_link_config;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  logic wr_general;
  logic wr_transmit;

  assign wr_general = reg_wr_in && (reg_addr_in == rf_link_cfg_pkg::ADDR_GENERAL_LINK_CONFIG);
  assign wr_transmit = reg_wr_in && (reg_addr_in == rf_link_cfg_pkg::ADDR_TRANSMIT_LINK_CONFIG);

  always_comb
  begin
    nxt_general_link_config = general_link_config_ff;
    nxt_transmit_link_config = transmit_link_config_ff;
    // Reserved bits keep their reset value; reserved slots store nothing
    if (wr_general)
    begin
      nxt_general_link_config = rf_link_cfg_pkg::merge_write(general_link_config_ff,
        reg_wdata_in, rf_link_cfg_pkg::GEN_WRITE_MASK);
    end
    if (wr_transmit)
    begin
      nxt_transmit_link_config = rf_link_cfg_pkg::merge_write(transmit_link_config_ff,
        reg_wdata_in, rf_link_cfg_pkg::TX_WRITE_MASK);
    end
  end

  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        rf_link_cfg_pkg::ADDR_RESERVED_SLOT_A: nxt_rdata = rf_link_cfg_pkg::RST_RESERVED_SLOT;
        rf_link_cfg_pkg::ADDR_RESERVED_SLOT_B: nxt_rdata = rf_link_cfg_pkg::RST_RESERVED_SLOT;
        rf_link_cfg_pkg::ADDR_GENERAL_LINK_CONFIG: nxt_rdata = general_link_config_ff;
        rf_link_cfg_pkg::ADDR_TRANSMIT_LINK_CONFIG:
        begin
          nxt_rdata = transmit_link_config_ff & rf_link_cfg_pkg::TX_WRITE_MASK;
        end
        default: nxt_rdata = rf_link_cfg_pkg::READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      general_link_config_ff <= rf_link_cfg_pkg::RST_GENERAL_LINK_CONFIG;
      transmit_link_config_ff <= rf_link_cfg_pkg::RST_TRANSMIT_LINK_CONFIG;
      rdata_ff <= rf_link_cfg_pkg::READ_UNMAPPED;
    end
    else if (ce_in)
    begin
      general_link_config_ff <= nxt_general_link_config;
      transmit_link_config_ff <= nxt_transmit_link_config;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_out = rdata_ff;

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  logic crc_order_select;
  logic tx_field_gating;
  logic aux_input_polarity;
  logic [1:0] crc_seed_select;
  logic tx_crc_append_en;
  logic [2:0] tx_rate_select;
  logic tx_modulation_invert;

  assign crc_order_select = general_link_config_ff[rf_link_cfg_pkg::GEN_CRC_ORDER_SELECT_BIT];
  assign tx_field_gating = general_link_config_ff[rf_link_cfg_pkg::GEN_TX_FIELD_GATING_BIT];
  assign aux_input_polarity = general_link_config_ff[rf_link_cfg_pkg::GEN_AUX_INPUT_POLARITY_BIT];
  assign crc_seed_select =
    general_link_config_ff[rf_link_cfg_pkg::GEN_CRC_SEED_SELECT_LSB +: 2];
  assign tx_crc_append_en = transmit_link_config_ff[rf_link_cfg_pkg::TX_CRC_APPEND_EN_BIT];
  assign tx_rate_select = transmit_link_config_ff[rf_link_cfg_pkg::TX_RATE_SELECT_LSB +: 3];
  assign tx_modulation_invert =
    transmit_link_config_ff[rf_link_cfg_pkg::TX_MODULATION_INVERT_BIT];

  // ------------------------------------------------------------
  // CRC seed and result ordering
  // ------------------------------------------------------------
  crc_cfg_if crc_bus ();

  assign crc_bus.order_select = crc_order_select;
  assign crc_bus.seed_select = crc_seed_select;
  assign crc_bus.rf_active = rf_comm_active_in;
  assign crc_bus.raw_result = crc_raw_in;

  crc_seed_unit u_crc_seed (
    .crc(crc_bus.unit)
  );

  logic [15:0] crc_seed_ff;
  logic [15:0] crc_result_ff;
  logic crc_msb_first_ff;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      crc_seed_ff <= rf_link_cfg_pkg::CRC_SEED_11;
      crc_result_ff <= rf_link_cfg_pkg::CRC_SEED_00;
      crc_msb_first_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      crc_seed_ff <= crc_bus.seed;
      crc_result_ff <= crc_bus.result;
      crc_msb_first_ff <= crc_bus.msb_first;
    end
  end

  assign crc_seed_out = crc_seed_ff;
  assign crc_result_value_out = crc_result_ff;
  assign crc_msb_first_out = crc_msb_first_ff;

  // ------------------------------------------------------------
  // Transmit control
  // ------------------------------------------------------------
  logic tx_start_ff;
  logic nxt_tx_start;
  logic tx_refused_ff;
  logic nxt_tx_refused;
  logic tx_busy_ff;
  logic nxt_tx_busy;
  logic tx_crc_append_ff;
  logic nxt_tx_crc_append;
  logic tx_mod_ff;
  logic nxt_tx_mod;
  logic tx_rate_reserved_ff;
  logic nxt_tx_rate_reserved;

  always_comb
  begin
    nxt_tx_start = 1'b0;
    nxt_tx_refused = 1'b0;
    nxt_tx_busy = tx_busy_ff;
    nxt_tx_crc_append = tx_crc_append_ff;
    if (tx_frame_end_in)
    begin
      nxt_tx_busy = 1'b0;
    end
    if (tx_start_req_in)
    begin
      // No field means the card has no power, so sending is pointless
      if (tx_field_gating && !rf_field_on_in)
      begin
        nxt_tx_refused = 1'b1;
      end
      else
      begin
        nxt_tx_start = 1'b1;
        nxt_tx_busy = 1'b1;
        // Latched per frame so a mid-frame write cannot split a CRC
        nxt_tx_crc_append = tx_crc_append_en;
      end
    end
    nxt_tx_mod = tx_data_in ^ tx_modulation_invert;
    case (tx_rate_select)
      rf_link_cfg_pkg::RATE_106: nxt_tx_rate_reserved = 1'b0;
      rf_link_cfg_pkg::RATE_212: nxt_tx_rate_reserved = 1'b0;
      rf_link_cfg_pkg::RATE_424: nxt_tx_rate_reserved = 1'b0;
      rf_link_cfg_pkg::RATE_848: nxt_tx_rate_reserved = 1'b0;
      default: nxt_tx_rate_reserved = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_start_ff <= 1'b0;
      tx_refused_ff <= 1'b0;
      tx_busy_ff <= 1'b0;
      tx_crc_append_ff <= 1'b0;
      tx_mod_ff <= 1'b0;
      tx_rate_reserved_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      tx_start_ff <= nxt_tx_start;
      tx_refused_ff <= nxt_tx_refused;
      tx_busy_ff <= nxt_tx_busy;
      tx_crc_append_ff <= nxt_tx_crc_append;
      tx_mod_ff <= nxt_tx_mod;
      tx_rate_reserved_ff <= nxt_tx_rate_reserved;
    end
  end

  assign tx_start_out = tx_start_ff;
  assign tx_start_refused_out = tx_refused_ff;
  assign tx_crc_append_out = tx_crc_append_ff;
  assign tx_mod_data_out = tx_mod_ff;
  assign tx_rate_reserved_out = tx_rate_reserved_ff;

  // Register fields shown as live settings; the host keeps CRC on above 106
  logic tx_crc_en_view_ff;
  logic [2:0] tx_rate_view_ff;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_crc_en_view_ff <= 1'b0;
      tx_rate_view_ff <= rf_link_cfg_pkg::RATE_106;
    end
    else if (ce_in)
    begin
      tx_crc_en_view_ff <= tx_crc_append_en;
      tx_rate_view_ff <= tx_rate_select;
    end
  end

  assign tx_crc_append_en_out = tx_crc_en_view_ff;
  assign tx_rate_select_out = tx_rate_view_ff;

  // ------------------------------------------------------------
  // Aux envelope input
  // ------------------------------------------------------------
  logic aux_env_n_ff;
  logic nxt_aux_env_n;
  logic aux_irq_ff;
  logic nxt_aux_irq;
  logic aux_asserted;

  always_comb
  begin
    aux_asserted = aux_input_polarity ? aux_envelope_input_in : ~aux_envelope_input_in;
    // Internal envelope is active low whatever the pin polarity
    nxt_aux_env_n = ~aux_asserted;
    // Flipping polarity flips the internal level, so flag it as activity
    nxt_aux_irq = wr_general &&
      (nxt_general_link_config[rf_link_cfg_pkg::GEN_AUX_INPUT_POLARITY_BIT] !=
       aux_input_polarity);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      aux_env_n_ff <= 1'b1;
      aux_irq_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      aux_env_n_ff <= nxt_aux_env_n;
      aux_irq_ff <= nxt_aux_irq;
    end
  end

  assign aux_envelope_n_out = aux_env_n_ff;
  assign aux_input_activity_irq_out = aux_irq_ff;

endmodule

`default_nettype wire

// ### tb/rf_link_mode_config_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module rf_link_cfg_chk (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic rf_comm_active_in,
  input wire logic [15:0] crc_raw_in,
  input wire logic tx_start_req_in,
  input wire logic rf_field_on_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [15:0] crc_seed_out,
  input wire logic [15:0] crc_result_value_out,
  input wire logic crc_msb_first_out,
  input wire logic tx_start_out,
  input wire logic tx_start_refused_out,
  input wire logic tx_crc_append_out,
  input wire logic [2:0] tx_rate_select_out,
  input wire logic tx_rate_reserved_out,
  input wire logic aux_input_activity_irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic [15:0] rev_raw;
  // Each result byte mirrored in place
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      rev_raw[15 - i] = crc_raw_in[8 + i];
      rev_raw[7 - i] = crc_raw_in[i];
    end
  end
  sequence s_start;
    ce_in && tx_start_req_in;
  endsequence
  sequence s_wr(logic [5:0] a);
    ce_in && reg_wr_in && reg_addr_in == a;
  endsequence
  a_start_accept: assert property (s_start ##0 rf_field_on_in |=> tx_start_out)
    else $error("start with field on not accepted");
  a_start_single: assert property (s_start |=> tx_start_out ^ tx_start_refused_out)
    else $error("start answer not exactly one pulse");
  a_refuse_cause: assert property (tx_start_refused_out |->
    $past(tx_start_req_in && !rf_field_on_in))
    else $error("refusal without unfielded request");
  a_crc_auto: assert property (ce_in && rf_comm_active_in |=> !crc_msb_first_out &&
    crc_seed_out == rf_link_cfg_pkg::CRC_AUTO_SEED)
    else $error("crc settings not automatic during rf");
  a_result_order: assert property (ce_in |=> crc_result_value_out ==
    (crc_msb_first_out ? $past(rev_raw) : $past(crc_raw_in)))
    else $error("crc result byte order wrong");
  a_rate_write: assert property (s_wr(6'h12) |=> ##1 tx_rate_select_out ==
    $past(reg_wdata_in[6:4], 2) && tx_rate_reserved_out == $past(reg_wdata_in[6], 2))
    else $error("rate field not taken from write");
  a_irq_cause: assert property (aux_input_activity_irq_out |->
    $past(ce_in && reg_wr_in && reg_addr_in == 6'h11))
    else $error("activity event without mode write");
  a_unmapped_zero: assert property (ce_in && reg_rd_in && !(reg_addr_in inside {6'h11, 6'h12})
    |=> reg_rdata_out == 8'h00)
    else $error("reserved or unmapped read not zero");
  a_rdata_hold: assert property (!(ce_in && reg_rd_in) |=> $stable(reg_rdata_out))
    else $error("read data changed without read");
  a_append_hold: assert property (!tx_start_out |-> $stable(tx_crc_append_out))
    else $error("crc append changed outside start");
endmodule
bind rf_link_mode_config_regs rf_link_cfg_chk u_chk (.clk_sys_in, .rst_in, .ce_in,
  .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .rf_comm_active_in, .crc_raw_in,
  .tx_start_req_in, .rf_field_on_in, .reg_rdata_out, .crc_seed_out, .crc_result_value_out,
  .crc_msb_first_out, .tx_start_out, .tx_start_refused_out, .tx_crc_append_out,
  .tx_rate_select_out, .tx_rate_reserved_out, .aux_input_activity_irq_out);
`default_nettype wire

// ### tb/rf_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module rf_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [5:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out
);
  initial
  begin
    addr_out = 6'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    // Crc enable stays set above the lowest rate
    if (a == 6'h12 && v[6:4] != 3'h0) v[7] = 1'b1;
    @(negedge clk_in);
    addr_out = a;
    wdata_out = v;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~v;
  endtask
  task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    @(negedge clk_in);
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// ### tb/test_rf_link_mode_config_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_rf_link_mode_config_regs;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce = 1'b1, rf = 1'b0, req = 1'b0, field = 1'b0, txd = 1'b0, aux = 1'b0;
  logic [15:0] raw = 16'h1234;
  logic [5:0] addr;
  logic wr, rd;
  logic [7:0] wdata, rdata, rv;
  logic [15:0] seed, result;
  logic msb, start, refused, append, append_en, rate_rsv, mod, env_n, irq;
  logic [2:0] rate;
  logic [15:0] seeds [4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
  int fails = 0, total_checks = 0, n_start = 0, n_ref = 0, n_irq = 0;

  always #25 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
  begin
    if (start === 1'b1) n_start++;
    if (refused === 1'b1) n_ref++;
    if (irq === 1'b1) n_irq++;
  end

  rf_host_model host (.clk_in(clk_sys_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
    .rd_out(rd), .wdata_out(wdata));
  rf_link_mode_config_regs uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .rf_comm_active_in(rf), .crc_raw_in(raw), .tx_start_req_in(req), .rf_field_on_in(field),
    .tx_frame_end_in(1'b0), .tx_data_in(txd), .aux_envelope_input_in(aux),
    .reg_rdata_out(rdata), .crc_seed_out(seed), .crc_result_value_out(result),
    .crc_msb_first_out(msb), .tx_start_out(start), .tx_start_refused_out(refused),
    .tx_crc_append_out(append), .tx_crc_append_en_out(append_en),
    .tx_rate_select_out(rate), .tx_rate_reserved_out(rate_rsv), .tx_mod_data_out(mod),
    .aux_envelope_n_out(env_n), .aux_input_activity_irq_out(irq));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    host.read_reg(a, rv);
    chk({8'h00, rv}, {8'h00, e});
  endtask
  task automatic pulse_req();
    @(negedge clk_sys_in);
    req = 1'b1;
    @(negedge clk_sys_in);
    req = 1'b0;
    cyc(2);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd_chk(6'h0f, 8'h00);
    rd_chk(6'h10, 8'h00);
    rd_chk(6'h11, 8'h3f);
    rd_chk(6'h12, 8'h00);
    chk(seed, 16'hffff);
  endtask
  task automatic t_reserved();
    host.write_reg(6'h0f, 8'hff);
    host.write_reg(6'h10, 8'hff);
    host.write_reg(6'h3f, 8'hff);
    rd_chk(6'h0f, 8'h00);
    rd_chk(6'h10, 8'h00);
    rd_chk(6'h3f, 8'h00);
    host.write_reg(6'h11, 8'h00);
    rd_chk(6'h11, 8'h14);
    host.write_reg(6'h12, 8'hff);
    rd_chk(6'h12, 8'hf8);
    host.write_reg(6'h12, 8'h00);
  endtask
  task automatic t_seed();
    for (int s = 0; s < 4; s++)
    begin
      host.write_reg(6'h11, 8'(s));
      cyc(3);
      chk(seed, seeds[s]);
    end
    rf = 1'b1;
    cyc(3);
    chk(seed, 16'h6363);
    rf = 1'b0;
  endtask
  task automatic t_order();
    host.write_reg(6'h11, 8'h80);
    cyc(3);
    chk({15'h0, msb}, 16'h0001);
    chk(result, 16'h482c);
    rf = 1'b1;
    cyc(3);
    chk({15'h0, msb}, 16'h0000);
    chk(result, 16'h1234);
    rf = 1'b0;
  endtask
  task automatic t_gating();
    host.write_reg(6'h11, 8'h20);
    n_start = 0;
    n_ref = 0;
    pulse_req();
    chk(16'(n_ref), 16'h0001);
    field = 1'b1;
    pulse_req();
    chk(16'(n_start), 16'h0001);
    host.write_reg(6'h11, 8'h00);
    field = 1'b0;
    pulse_req();
    chk(16'(n_start), 16'h0002);
    chk(16'(n_ref), 16'h0001);
  endtask
  task automatic t_append();
    host.write_reg(6'h12, 8'h80);
    pulse_req();
    chk({15'h0, append}, 16'h0001);
    host.write_reg(6'h12, 8'h00);
    cyc(1);
    chk({15'h0, append_en}, 16'h0000);
    chk({15'h0, append}, 16'h0001);
    pulse_req();
    chk({15'h0, append}, 16'h0000);
  endtask
  task automatic t_rate();
    for (int c = 0; c < 8; c++)
    begin
      host.write_reg(6'h12, {1'b1, 3'(c), 4'h0});
      cyc(1);
      chk({13'h0, rate}, 16'(c));
      chk({15'h0, rate_rsv}, 16'(c / 4));
    end
    host.write_reg(6'h12, 8'h00);
  endtask
  task automatic t_invert();
    txd = 1'b1;
    host.write_reg(6'h12, 8'h08);
    cyc(2);
    chk({15'h0, mod}, 16'h0000);
    txd = 1'b0;
    cyc(2);
    chk({15'h0, mod}, 16'h0001);
    host.write_reg(6'h12, 8'h00);
    cyc(2);
    chk({15'h0, mod}, 16'h0000);
  endtask
  task automatic t_aux();
    aux = 1'b1;
    cyc(2);
    chk({15'h0, env_n}, 16'h0001);
    n_irq = 0;
    host.write_reg(6'h11, 8'h08);
    cyc(2);
    chk(16'(n_irq), 16'h0001);
    chk({15'h0, env_n}, 16'h0000);
    host.write_reg(6'h11, 8'h08);
    cyc(2);
    chk(16'(n_irq), 16'h0001);
  endtask
  task automatic t_freeze_reset();
    ce = 1'b0;
    host.write_reg(6'h12, 8'h08);
    ce = 1'b1;
    rd_chk(6'h12, 8'h00);
    @(negedge clk_sys_in);
    rst_in = 1'b1;
    cyc(2);
    rst_in = 1'b0;
    rd_chk(6'h11, 8'h3f);
  endtask

  // Hang guard, far beyond the normal run length
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    fails++;
    tally_and_finish();
  end
  initial
  begin
    cyc(6);
    rst_in = 1'b0;
    t_reset();
    t_reserved();
    t_seed();
    t_order();
    t_gating();
    t_append();
    t_rate();
    t_invert();
    t_aux();
    t_freeze_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
